// >>> rtl/rla_defs.svh
`ifndef RLA_DEFS_SVH
`define RLA_DEFS_SVH

// Register byte offsets
`define RLA_ADR_CTRL 4'h0
`define RLA_ADR_STATUS 4'h4
`define RLA_ADR_INT_STAT 4'h8
`define RLA_ADR_INT_MASK 4'hC

// Control register fields
`define RLA_CTRL_LOSS_SHUTDOWN 0
`define RLA_CTRL_AIS_INSERT 1
`define RLA_CTRL_POLARITY 2
`define RLA_CTRL_FULL_LOOP 3
`define RLA_CTRL_REMOTE_LOOP 4
`define RLA_CTRL_LOCAL_LOOP 5
`define RLA_CTRL_ANALOG_LOSS_ALARM_TIMER 6
`define RLA_CTRL_LOSS_STD 7
`define RLA_CTRL_CLK_SCALE 8
`define RLA_CTRL_E1_MODE 9
`define RLA_CTRL_ZERO_SUBST 10
`define RLA_CTRL_DUAL_RAIL 11
`define RLA_CTRL_WIDTH 12
`define RLA_CTRL_RST 12'h000

// Status register fields
`define RLA_STAT_DIGITAL_LOSS_ALARM 0
`define RLA_STAT_ANALOG_LOSS_ALARM 1
`define RLA_STAT_FREE_RUN 2

// Interrupt status and mask fields
`define RLA_INT_DIGITAL_LOSS_ALARM 0
`define RLA_INT_ANALOG_LOSS_ALARM 1
`define RLA_INT_VIOL 2
`define RLA_INT_WIDTH 3
`define RLA_INT_RST 3'h0

// Digital loss thresholds, counted in bit positions
`define RLA_DS1_LOS_ZEROS 8'h64
`define RLA_E1_LOS_ZEROS 8'hFF
`define RLA_DS1_WINDOW 8'h64
`define RLA_E1_WINDOW 8'hFF
`define RLA_DS1_ONES_MIN 8'h0D
`define RLA_E1_ONES_MIN 8'h20
`define RLA_DS1_RUN_STRICT 8'h0F
`define RLA_DS1_RUN_LOOSE 8'h63
`define RLA_E1_RUN_MAX 8'hFF

// Analog loss timing
`define RLA_ANALOG_LOSS_ALARM_MIN_TIME_US 1000
`define RLA_CLK_FREQ_MHZ 100
`define RLA_ANALOG_LOSS_ALARM_CYCLES (`RLA_ANALOG_LOSS_ALARM_MIN_TIME_US * `RLA_CLK_FREQ_MHZ)
`define RLA_ANALOG_LOSS_ALARM_UI_TICKS 8'h0B

// Free-run divider terminal count (reference / 16)
`define RLA_FR_DIV_LAST 4'hF

`endif

// >>> rtl/rla_pkg.sv
package rla_pkg;

    typedef enum logic [1:0] {
        RLA_SRC_NORMAL = 2'b00,
        RLA_SRC_INACTIVE = 2'b01,
        RLA_SRC_AIS = 2'b10
    } rla_src_t;

endpackage

// >>> rtl/rla_digital_loss_alarm.sv
`timescale 1ns/1ps
`include "rla_defs.svh"

module rla_digital_loss_alarm import rla_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bit stream
    input wire logic bit_en_i,
    input wire logic mark_i,
    input wire logic e1_mode_i,
    input wire logic strict_std_i,
    // Alarm
    output logic alarm_o
);

    logic [7:0] zero_run_q;
    logic [7:0] zero_run_d;
    logic [7:0] win_cnt_q;
    logic [7:0] ones_q;
    logic [7:0] ones_d;
    logic [7:0] win_run_q;
    logic [7:0] win_run_d;
    logic win_bad_q;
    logic win_bad_d;
    logic alarm_q;
    logic [7:0] los_thr;
    logic [7:0] win_last;
    logic [7:0] ones_min;
    logic [7:0] run_max;

    always_comb begin
        los_thr = e1_mode_i ? `RLA_E1_LOS_ZEROS : `RLA_DS1_LOS_ZEROS;
        win_last = (e1_mode_i ? `RLA_E1_WINDOW : `RLA_DS1_WINDOW) - 8'h01;
        ones_min = e1_mode_i ? `RLA_E1_ONES_MIN : `RLA_DS1_ONES_MIN;
        if (e1_mode_i) begin
            run_max = `RLA_E1_RUN_MAX;
        end else if (strict_std_i) begin
            run_max = `RLA_DS1_RUN_STRICT;
        end else begin
            run_max = `RLA_DS1_RUN_LOOSE;
        end
        zero_run_d = mark_i ? 8'h00 :
            ((zero_run_q == 8'hFF) ? 8'hFF : zero_run_q + 8'h01);
        win_run_d = mark_i ? 8'h00 :
            ((win_run_q == 8'hFF) ? 8'hFF : win_run_q + 8'h01);
        ones_d = ones_q + {7'h00, mark_i};
        win_bad_d = win_bad_q | (win_run_d > run_max);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_run_q <= 8'h00;
        end else if (bit_en_i) begin
            zero_run_q <= zero_run_d;
        end
    end

    // Alarm and ones-density window while alarmed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_q <= 1'b0;
            win_cnt_q <= 8'h00;
            ones_q <= 8'h00;
            win_run_q <= 8'h00;
            win_bad_q <= 1'b0;
        end else if (bit_en_i) begin
            if (!alarm_q) begin
                alarm_q <= (zero_run_d >= los_thr);
                win_cnt_q <= 8'h00;
                ones_q <= 8'h00;
                win_run_q <= 8'h00;
                win_bad_q <= 1'b0;
            end else if (win_cnt_q == win_last) begin
                if (ones_d >= ones_min && !win_bad_d) begin
                    alarm_q <= 1'b0;
                end
                win_cnt_q <= 8'h00;
                ones_q <= 8'h00;
                win_run_q <= 8'h00;
                win_bad_q <= 1'b0;
            end else begin
                win_cnt_q <= win_cnt_q + 8'h01;
                ones_q <= ones_d;
                win_run_q <= win_run_d;
                win_bad_q <= win_bad_d;
            end
        end
    end

    assign alarm_o = alarm_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ds1_assert_a: assert property (
        (bit_en_i && !mark_i && !e1_mode_i && !alarm_q
            && zero_run_q == 8'h63) |=> alarm_q)
        else $error("DS1 loss not raised at 100 zeros");

    e1_assert_a: assert property (
        (bit_en_i && !mark_i && e1_mode_i && !alarm_q
            && zero_run_q == 8'hFE) |=> alarm_q)
        else $error("E1 loss not raised at 255 zeros");

    clear_density_a: assert property (
        $fell(alarm_q) |-> $past(ones_d) >= $past(ones_min)
            && !$past(win_bad_d))
        else $error("Loss cleared without ones density");

endmodule // rla_digital_loss_alarm

// >>> rtl/rla_analog_loss_alarm.sv
`timescale 1ns/1ps
`include "rla_defs.svh"

module rla_analog_loss_alarm import rla_pkg::*; #(
    parameter int ANALOG_LOSS_ALARM_CYCLES = `RLA_ANALOG_LOSS_ALARM_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Detector input and timing
    input wire logic absent_i,
    input wire logic ui_mode_i,
    input wire logic ui_tick_i,
    // Alarm
    output logic alarm_o
);

    localparam logic [16:0] CYC_LAST = 17'(ANALOG_LOSS_ALARM_CYCLES - 1);

    logic [16:0] cyc_q;
    logic [7:0] ui_q;
    logic alarm_q;

    // Reference-clock timer and bit-period timer
    always_ff @(posedge clk_i) begin
        if (rst_i || !absent_i) begin
            cyc_q <= 17'h00000;
            ui_q <= 8'h00;
        end else begin
            if (cyc_q != CYC_LAST) begin
                cyc_q <= cyc_q + 17'h00001;
            end
            if (ui_tick_i && ui_q != `RLA_ANALOG_LOSS_ALARM_UI_TICKS) begin
                ui_q <= ui_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !absent_i) begin
            alarm_q <= 1'b0;
        end else if (!ui_mode_i && cyc_q == CYC_LAST) begin
            alarm_q <= 1'b1;
        end else if (ui_mode_i && ui_q == `RLA_ANALOG_LOSS_ALARM_UI_TICKS) begin
            alarm_q <= 1'b1;
        end
    end

    assign alarm_o = alarm_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ms_timer_a: assert property (
        ($rose(alarm_q) && !$past(ui_mode_i)) |->
            $past(cyc_q) == CYC_LAST && $past(absent_i))
        else $error("Analog loss raised off the ms timer");

    ui_timer_a: assert property (
        ($rose(alarm_q) && $past(ui_mode_i)) |->
            $past(ui_q) == `RLA_ANALOG_LOSS_ALARM_UI_TICKS)
        else $error("Analog loss raised off the bit timer");

    signal_back_a: assert property (
        !absent_i |=> !alarm_q)
        else $error("Analog loss held after signal returned");

endmodule // rla_analog_loss_alarm

// >>> rtl/rla_rx_alarm_ctl.sv
// Overview of operation
// - Digital loss alone passes data and clock
// - Analog loss forces inactive rails, free clock
// - AIS setting sends all ones on loss
// - Shutdown forces inactive rails on either loss
// - Loopback disables all loss substitutions
// - Uncoded single-rail flags every bipolar violation
// - Coded single-rail flags substitution code violations
// - DS1 loss clears on density, zero limit
// - E1 loss after 255 zeros, density clears
// - Analog loss timer between 1.0, 2.6 ms
// - Bit timer declares within 10 to 255
// - DS1 loss after 100 consecutive zeros
// - Free clock is reference or reference/16
// - Polarity select sets active and inactive levels
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "rla_defs.svh"

module rla_rx_alarm_ctl import rla_pkg::*; #(
    parameter int ANALOG_LOSS_ALARM_CYCLES = `RLA_ANALOG_LOSS_ALARM_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Line receiver side
    input wire logic line_bit_en_i,
    input wire logic line_pos_i,
    input wire logic line_neg_i,
    input wire logic analog_absent_i,
    // System side
    output logic rx_positive_rail_o,
    output logic rx_negative_rail_o,
    output logic rx_clk_en_o,
    output logic digital_loss_alarm_o,
    output logic analog_loss_alarm_o,
    output logic irq_o
);

    logic [`RLA_CTRL_WIDTH-1:0] ctrl_q;
    logic [`RLA_INT_WIDTH-1:0] int_stat_q;
    logic [`RLA_INT_WIDTH-1:0] int_mask_q;
    logic [`RLA_INT_WIDTH-1:0] int_evt;
    logic loss_shutdown_sel;
    logic rx_ais_insert_sel;
    logic data_polarity_sel;
    logic loop_any;
    logic analog_loss_timer_sel;
    logic loss_standard_sel;
    logic ref_clock_scale_sel;
    logic e1_mode_sel;
    logic zero_subst_sel;
    logic dual_rail_sel;
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_data;
    logic [3:0] div_q;
    logic fr_tick;
    logic digital_loss_alarm;
    logic analog_loss_alarm;
    logic digital_loss_alarm_q;
    logic analog_loss_alarm_q;
    logic mark;
    logic had_mark_q;
    logic last_pos_q;
    logic [2:0] hist_q;
    logic [2:0] vhist_q;
    logic violation_flag;
    logic sub_ok;
    logic viol;
    logic viol_q;
    rla_src_t src_d;
    rla_src_t src_q;
    logic pos_norm;
    logic neg_norm;

    // Address decode, shared by read and write paths
    function automatic logic hit(input logic [3:0] adr,
                                 input logic [3:0] reg_adr);
        hit = (adr[3:2] == reg_adr[3:2]);
    endfunction

    assign loss_shutdown_sel = ctrl_q[`RLA_CTRL_LOSS_SHUTDOWN];
    assign rx_ais_insert_sel = ctrl_q[`RLA_CTRL_AIS_INSERT];
    assign data_polarity_sel = ctrl_q[`RLA_CTRL_POLARITY];
    assign loop_any = ctrl_q[`RLA_CTRL_FULL_LOOP]
        | ctrl_q[`RLA_CTRL_REMOTE_LOOP] | ctrl_q[`RLA_CTRL_LOCAL_LOOP];
    assign analog_loss_timer_sel = ctrl_q[`RLA_CTRL_ANALOG_LOSS_ALARM_TIMER];
    assign loss_standard_sel = ctrl_q[`RLA_CTRL_LOSS_STD];
    assign ref_clock_scale_sel = ctrl_q[`RLA_CTRL_CLK_SCALE];
    assign e1_mode_sel = ctrl_q[`RLA_CTRL_E1_MODE];
    assign zero_subst_sel = ctrl_q[`RLA_CTRL_ZERO_SUBST];
    assign dual_rail_sel = ctrl_q[`RLA_CTRL_DUAL_RAIL];

    // Bus slave: one wait state; writes land on the edge that sees ack
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit(wb_adr_i, `RLA_ADR_CTRL)) begin
            rd_data[`RLA_CTRL_WIDTH-1:0] = ctrl_q;
        end else if (hit(wb_adr_i, `RLA_ADR_STATUS)) begin
            rd_data[`RLA_STAT_DIGITAL_LOSS_ALARM] = digital_loss_alarm_q;
            rd_data[`RLA_STAT_ANALOG_LOSS_ALARM] = analog_loss_alarm_q;
            rd_data[`RLA_STAT_FREE_RUN] = (src_q != RLA_SRC_NORMAL);
        end else if (hit(wb_adr_i, `RLA_ADR_INT_STAT)) begin
            rd_data[`RLA_INT_WIDTH-1:0] = int_stat_q;
        end else begin
            rd_data[`RLA_INT_WIDTH-1:0] = int_mask_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `RLA_CTRL_RST;
        end else if (bus_wr && hit(wb_adr_i, `RLA_ADR_CTRL)) begin
            if (wb_sel_i[0]) begin
                ctrl_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                ctrl_q[`RLA_CTRL_WIDTH-1:8] <=
                    wb_dat_i[`RLA_CTRL_WIDTH-1:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_mask_q <= `RLA_INT_RST;
        end else if (bus_wr && wb_sel_i[0]
                     && hit(wb_adr_i, `RLA_ADR_INT_MASK)) begin
            int_mask_q <= wb_dat_i[`RLA_INT_WIDTH-1:0];
        end
    end

    // Sticky events; a new event wins over a write-one clear
    assign int_evt[`RLA_INT_DIGITAL_LOSS_ALARM] = digital_loss_alarm && !digital_loss_alarm_q;
    assign int_evt[`RLA_INT_ANALOG_LOSS_ALARM] = analog_loss_alarm && !analog_loss_alarm_q;
    assign int_evt[`RLA_INT_VIOL] = viol_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_stat_q <= `RLA_INT_RST;
        end else if (bus_wr && wb_sel_i[0]
                     && hit(wb_adr_i, `RLA_ADR_INT_STAT)) begin
            int_stat_q <= (int_stat_q & ~wb_dat_i[`RLA_INT_WIDTH-1:0])
                | int_evt;
        end else begin
            int_stat_q <= int_stat_q | int_evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_stat_q & int_mask_q);
        end
    end

    // Free-running bit timing from the reference clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    assign fr_tick = ref_clock_scale_sel || (div_q == `RLA_FR_DIV_LAST);

    // Loss detectors
    assign mark = line_pos_i | line_neg_i;

    rla_digital_loss_alarm u_digital_loss_alarm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bit_en_i(line_bit_en_i),
        .mark_i(mark),
        .e1_mode_i(e1_mode_sel),
        .strict_std_i(loss_standard_sel),
        .alarm_o(digital_loss_alarm)
    );

    rla_analog_loss_alarm #(
        .ANALOG_LOSS_ALARM_CYCLES(ANALOG_LOSS_ALARM_CYCLES)
    ) u_analog_loss_alarm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .absent_i(analog_absent_i),
        .ui_mode_i(analog_loss_timer_sel),
        .ui_tick_i(fr_tick),
        .alarm_o(analog_loss_alarm)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            digital_loss_alarm_q <= 1'b0;
            analog_loss_alarm_q <= 1'b0;
        end else begin
            digital_loss_alarm_q <= digital_loss_alarm;
            analog_loss_alarm_q <= analog_loss_alarm;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            digital_loss_alarm_o <= 1'b0;
            analog_loss_alarm_o <= 1'b0;
        end else begin
            digital_loss_alarm_o <= digital_loss_alarm;
            analog_loss_alarm_o <= analog_loss_alarm;
        end
    end

    // Violation detection on the bipolar marks
    always_comb begin
        violation_flag = line_pos_i && line_neg_i;
        if (mark && had_mark_q && (line_pos_i == last_pos_q)) begin
            violation_flag = 1'b1;
        end
        if (e1_mode_sel) begin
            sub_ok = !hist_q[0] && !hist_q[1];
        end else begin
            sub_ok = (hist_q == 3'h0) || (!hist_q[0] && vhist_q[2]);
        end
        viol = zero_subst_sel ? (violation_flag && !sub_ok) : violation_flag;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            had_mark_q <= 1'b0;
            last_pos_q <= 1'b0;
            hist_q <= 3'h0;
            vhist_q <= 3'h0;
            viol_q <= 1'b0;
        end else if (line_bit_en_i) begin
            if (mark) begin
                had_mark_q <= 1'b1;
                last_pos_q <= line_pos_i;
            end
            hist_q <= {hist_q[1:0], mark};
            vhist_q <= {vhist_q[1:0], violation_flag && sub_ok};
            viol_q <= viol && !dual_rail_sel;
        end else begin
            viol_q <= 1'b0;
        end
    end

    // Output source from registered alarms only
    always_comb begin
        if (loop_any) begin
            src_d = RLA_SRC_NORMAL;
        end else if (loss_shutdown_sel) begin
            src_d = (digital_loss_alarm_q || analog_loss_alarm_q) ? RLA_SRC_INACTIVE
                : RLA_SRC_NORMAL;
        end else if (rx_ais_insert_sel) begin
            src_d = (digital_loss_alarm_q || analog_loss_alarm_q) ? RLA_SRC_AIS
                : RLA_SRC_NORMAL;
        end else begin
            src_d = analog_loss_alarm_q ? RLA_SRC_INACTIVE : RLA_SRC_NORMAL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= RLA_SRC_NORMAL;
        end else begin
            src_q <= src_d;
        end
    end

    assign pos_norm = dual_rail_sel ? line_pos_i : mark;
    assign neg_norm = dual_rail_sel ? line_neg_i : viol;

    // Rails and clock enable, all from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_positive_rail_o <= 1'b1;
            rx_negative_rail_o <= 1'b1;
            rx_clk_en_o <= 1'b0;
        end else begin
            case (src_q)
                RLA_SRC_NORMAL: begin
                    rx_clk_en_o <= line_bit_en_i;
                    if (line_bit_en_i) begin
                        rx_positive_rail_o <=
                            pos_norm ~^ data_polarity_sel;
                        rx_negative_rail_o <=
                            neg_norm ~^ data_polarity_sel;
                    end
                end
                RLA_SRC_INACTIVE: begin
                    rx_clk_en_o <= fr_tick;
                    rx_positive_rail_o <= !data_polarity_sel;
                    rx_negative_rail_o <= !data_polarity_sel;
                end
                RLA_SRC_AIS: begin
                    rx_clk_en_o <= fr_tick;
                    if (fr_tick) begin
                        rx_positive_rail_o <= data_polarity_sel;
                        rx_negative_rail_o <= data_polarity_sel;
                    end
                end
                default: begin
                    rx_clk_en_o <= fr_tick;
                    rx_positive_rail_o <= !data_polarity_sel;
                    rx_negative_rail_o <= !data_polarity_sel;
                end
            endcase
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence analog_loss_alarm_only_s;
        analog_loss_alarm_q && !loss_shutdown_sel && !rx_ais_insert_sel && !loop_any;
    endsequence

    sequence digital_loss_alarm_only_s;
        digital_loss_alarm_q && !analog_loss_alarm_q && !loss_shutdown_sel && !rx_ais_insert_sel
            && !loop_any;
    endsequence

    sequence ais_s;
        (digital_loss_alarm_q || analog_loss_alarm_q) && rx_ais_insert_sel && !loss_shutdown_sel
            && !loop_any;
    endsequence

    sequence shut_s;
        (digital_loss_alarm_q || analog_loss_alarm_q) && loss_shutdown_sel && !loop_any;
    endsequence

    bus_ack_once_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus ack held more than one cycle");

    digital_loss_alarm_pass_a: assert property (
        digital_loss_alarm_only_s ##1 (digital_loss_alarm_only_s and (line_bit_en_i && dual_rail_sel
            && data_polarity_sel)) |=> rx_clk_en_o
            && rx_positive_rail_o == $past(line_pos_i))
        else $error("Digital loss altered rails or clock");

    analog_loss_alarm_inactive_a: assert property (
        analog_loss_alarm_only_s ##1 analog_loss_alarm_only_s |=>
            rx_positive_rail_o == !$past(data_polarity_sel)
            && rx_negative_rail_o == !$past(data_polarity_sel))
        else $error("Analog loss did not force inactive rails");

    ais_ones_a: assert property (
        ais_s ##1 (ais_s and fr_tick) |=> rx_clk_en_o
            && rx_positive_rail_o == $past(data_polarity_sel)
            && rx_negative_rail_o == $past(data_polarity_sel))
        else $error("AIS not sent on loss");

    shutdown_a: assert property (
        shut_s ##1 shut_s |=>
            rx_positive_rail_o == !$past(data_polarity_sel))
        else $error("Shutdown did not force inactive rails");

    loop_pass_a: assert property (
        loop_any ##1 (loop_any && line_bit_en_i && dual_rail_sel
            && data_polarity_sel) |=> rx_clk_en_o
            && rx_negative_rail_o == $past(line_neg_i))
        else $error("Loopback data altered by alarms");

    bpv_flag_a: assert property (
        (src_q == RLA_SRC_NORMAL && line_bit_en_i && !dual_rail_sel
            && !zero_subst_sel && data_polarity_sel && line_pos_i
            && !line_neg_i && had_mark_q && last_pos_q)
            |=> rx_negative_rail_o ##1 viol_q == 1'b0
            || line_bit_en_i)
        else $error("Bipolar violation not flagged");

    code_ok_a: assert property (
        (src_q == RLA_SRC_NORMAL && line_bit_en_i && !dual_rail_sel
            && zero_subst_sel && e1_mode_sel && data_polarity_sel
            && line_pos_i && !line_neg_i && had_mark_q && last_pos_q
            && hist_q[1:0] == 2'h0) |=> !rx_negative_rail_o)
        else $error("Valid substitution flagged as violation");

    free_div_a: assert property (
        (fr_tick && !ref_clock_scale_sel) |=>
            (!fr_tick || ref_clock_scale_sel)[*8] ##1 (!fr_tick
            || ref_clock_scale_sel)[*7] ##1 (fr_tick || ref_clock_scale_sel))
        else $error("Free-run tick spacing wrong");

    irq_level_a: assert property (
        irq_o == $past(|(int_stat_q & int_mask_q)))
        else $error("Interrupt output not following unmasked status");

endmodule // rla_rx_alarm_ctl

// >>> dv/rla_framer_model.sv
`timescale 1ns/1ps
module rla_framer_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Recovered stream
    input wire logic pos_i,
    input wire logic neg_i,
    input wire logic clk_en_i,
    // Observations
    output logic [15:0] ticks_o,
    output logic [1:0] last_o
);
    // Takes a bit only on a clock strobe, as the framer would
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ticks_o <= 16'h0000;
            last_o <= 2'h0;
        end else if (clk_en_i) begin
            ticks_o <= ticks_o + 16'h0001;
            last_o <= {pos_i, neg_i};
        end
    end
endmodule // rla_framer_model

// >>> dv/receive_loss_alarm_output_control_bench.sv
`timescale 1ns/1ps
module receive_loss_alarm_output_control_bench;
    import rla_pkg::*;
    typedef struct {
        logic [31:0] ctrl;
        logic [1:0] rails;
        logic [15:0] ticks;
    } rla_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, bit_en = 1'b0, pos = 1'b0, neg = 1'b0, absent = 1'b0;
    logic rp, rn, ce, dla, ala, irq, alt = 1'b0, marks_on = 1'b1;
    logic [1:0] ph = 2'h0;
    logic same_pol = 1'b0;
    logic [15:0] ticks;
    int err_count = 0;
    int n_tests = 0;
    // Loss rows: control word, rails, strobes seen in 16 cycles
    rla_row_t rows [7] = '{'{32'h104, 2'b00, 16'h10},
        '{32'h106, 2'b11, 16'h10}, '{32'h105, 2'b00, 16'h10},
        '{32'h107, 2'b00, 16'h10}, '{32'h100, 2'b11, 16'h10},
        '{32'h004, 2'b00, 16'h1}, '{32'h10E, 2'b10, 16'h4}};

    always #5 clk_i = ~clk_i;

    // A bit every fourth cycle, marks alternate unless same_pol is set
    always @(posedge clk_i) begin
        ph <= ph + 2'h1;
        bit_en <= (ph == 2'h3);
        pos <= marks_on & (ph == 2'h3) & (~alt | same_pol);
        neg <= marks_on & (ph == 2'h3) & alt & ~same_pol;
        if (ph == 2'h3) alt <= ~alt;
    end

    rla_rx_alarm_ctl #(.ANALOG_LOSS_ALARM_CYCLES(50)) i_dut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .line_bit_en_i(bit_en),
        .line_pos_i(pos), .line_neg_i(neg), .analog_absent_i(absent),
        .rx_positive_rail_o(rp), .rx_negative_rail_o(rn),
        .rx_clk_en_o(ce), .digital_loss_alarm_o(dla),
        .analog_loss_alarm_o(ala), .irq_o(irq));

    rla_framer_model i_framer (.clk_i(clk_i), .rst_i(rst_i),
        .pos_i(rp), .neg_i(rn), .clk_en_i(ce), .ticks_o(ticks),
        .last_o());

    task automatic wb(input logic w, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) err_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        finish_test();
    end

    initial begin
        int n;
        logic [31:0] q;
        logic [15:0] t0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(irq, 0);
        wb(1'b0, 4'h0, 0, q);
        chk(q, 0);
        wb(1'b0, 4'hC, 0, q);
        chk(q, 0);
        wb(1'b1, 4'h0, 32'h804, q);
        marks_on <= 1'b0;
        for (n = 0; n < 1200 && dla !== 1'b1; n++) @(posedge clk_i);
        chk(dla, 1);
        chk(32'(n >= 390), 1);
        t0 = ticks;
        repeat (16) @(posedge clk_i);
        chk(ticks - t0, 4);
        chk({rp, rn}, 2'b00);
        wb(1'b1, 4'h0, 32'h106, q);
        repeat (8) @(posedge clk_i);
        chk({rp, rn}, 2'b11);
        wb(1'b1, 4'h0, 0, q);
        marks_on <= 1'b1;
        for (n = 0; n < 1500 && dla !== 1'b0; n++) @(posedge clk_i);
        chk(dla, 0);
        absent <= 1'b1;
        repeat (40) @(posedge clk_i);
        chk(ala, 0);
        for (n = 0; n < 200 && ala !== 1'b1; n++) @(posedge clk_i);
        chk(ala, 1);
        chk(irq, 0);
        wb(1'b0, 4'h4, 0, q);
        chk(q, 32'h6);
        wb(1'b1, 4'hC, 32'h2, q);
        repeat (2) @(posedge clk_i);
        chk(irq, 1);
        wb(1'b1, 4'h8, 32'h2, q);
        repeat (2) @(posedge clk_i);
        chk(irq, 0);
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, 4'h0, rows[i].ctrl, q);
            repeat (8) @(posedge clk_i);
            t0 = ticks;
            repeat (16) @(posedge clk_i);
            chk({rp, rn}, rows[i].rails);
            chk(ticks - t0, rows[i].ticks);
        end
        absent <= 1'b0;
        wb(1'b1, 4'h0, 32'h140, q);
        absent <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(ala, 0);
        for (n = 0; n < 40 && ala !== 1'b1; n++) @(posedge clk_i);
        chk(ala, 1);
        absent <= 1'b0;
        wb(1'b1, 4'h0, 32'h004, q);
        same_pol <= 1'b1;
        repeat (16) @(posedge clk_i);
        chk({rp, rn}, 2'b11);
        wb(1'b0, 4'h8, 0, q);
        chk(32'(q[2]), 1);
        wb(1'b1, 4'h0, 32'h404, q);
        repeat (16) @(posedge clk_i);
        chk({rp, rn}, 2'b11);
        same_pol <= 1'b0;
        wb(1'b1, 4'h0, 32'h200, q);
        marks_on <= 1'b0;
        for (n = 0; n < 1200 && dla !== 1'b1; n++) @(posedge clk_i);
        chk(dla, 1);
        chk(32'(n >= 1000), 1);
        marks_on <= 1'b1;
        for (n = 0; n < 1500 && dla !== 1'b0; n++) @(posedge clk_i);
        chk(dla, 0);
        finish_test();
    end
endmodule // receive_loss_alarm_output_control_bench
